// file: design/pbss_pkg.sv
package pbss_pkg;
  // Array organisation
  localparam int PBSS_WORDS = 32768;
  localparam int PBSS_ADDR_W = 15;
  localparam int PBSS_UPPER_W = 13;
  localparam int PBSS_DATA_W = 36;
  localparam int PBSS_LANES = 4;
  localparam int PBSS_LANE_W = 9;
  // Lane positions: a is the lowest nine bits, d the highest
  localparam int PBSS_LANE_A_LSB = 0;
  localparam int PBSS_LANE_B_LSB = 9;
  localparam int PBSS_LANE_C_LSB = 18;
  localparam int PBSS_LANE_D_LSB = 27;
  localparam logic [3:0] PBSS_ALL_LANES = 4'hF;
  localparam logic [3:0] PBSS_NO_LANES = 4'h0;
  localparam logic [1:0] PBSS_CNT_START = 2'h0;
  localparam logic [1:0] PBSS_CNT_STEP = 2'h1;
  // Burst order select levels
  localparam logic PBSS_ORDER_LINEAR = 1'b0;
  localparam logic PBSS_ORDER_INTERLEAVED = 1'b1;

  typedef enum logic [0:0] {
    PBSS_PH_IDLE = 1'b0,
    PBSS_PH_BURST = 1'b1
  } pbss_phase_t;

  typedef struct packed {
    pbss_phase_t phase;
    logic [1:0] base;
    logic [1:0] cnt;
    logic [PBSS_UPPER_W-1:0] upper;
    logic cyc_valid;
    logic cyc_write;
    logic [PBSS_LANES-1:0] cyc_lanes;
    logic [PBSS_ADDR_W-1:0] cyc_addr;
    logic [PBSS_DATA_W-1:0] cyc_data;
    logic out_valid;
    logic [PBSS_DATA_W-1:0] out_data;
  } pbss_state_t;

  localparam pbss_state_t PBSS_STATE_RST = '0;
endpackage

// file: design/pbss_burst_addr.sv
`timescale 1ns/10ps
module pbss_burst_addr (
  input wire logic [1:0] base, // Low pair of the external start address
  input wire logic [1:0] cnt, // Steps taken since the burst began
  input wire logic order_sel, // Low linear, high interleaved
  output logic [1:0] pair // Low address pair for this step
);
  import pbss_pkg::*;

  // Linear wraps modulo four, interleaved flips bits of the start pair
  always_comb begin
    if (order_sel == PBSS_ORDER_INTERLEAVED) begin
      pair = base ^ cnt;
    end else begin
      pair = 2'(base + cnt);
    end
  end
endmodule

// file: design/pbss_sram.sv
`timescale 1ns/10ps
// Operation
// - Inputs captured on rising clock edge
// - Array of 32K words, 36 bits
// - Two-bit counter supplies burst low bits
// - Either strobe starts burst at external address
// - Later addresses generated internally, order selectable
// - Step advances counter, otherwise address held
// - Write starts at edge, internally timed
// - Byte write touches only enabled lanes
// - Global write writes all four lanes
// - Write enable with all bytes writes all
// - Each byte enable owns its lane
// - Read data goes through output register
// - Processor strobe ignored while chip select high
// - Controller strobe starts read, write or deselect
// - High chip select with controller strobe deselects
// - High-active chip select gates new accesses
// - Output enable acts asynchronously on drivers
// - Burst order level static, low linear
// - Linear order counts upward modulo four
// - Write means global or enable plus byte
module pbss_sram (
  input wire logic CORE_CLK, // 20 MHz clock
  input wire logic SYS_RST, // Synchronous reset, active high
  input wire logic [pbss_pkg::PBSS_UPPER_W-1:0] ADDRESS_IN, // Upper address bits
  input wire logic [1:0] BURST_LSB_PAIR, // Two lowest address bits
  input wire logic [pbss_pkg::PBSS_LANES-1:0] BYTE_WRITE_N, // Byte enables, bit 0 is lane a
  input wire logic WRITE_ENABLE_N, // Qualifies byte enables
  input wire logic GLOBAL_WRITE_N, // Writes every lane
  input wire logic PROC_ADDR_STROBE_N, // Processor address strobe
  input wire logic CTRL_ADDR_STROBE_N, // Controller address strobe
  input wire logic BURST_STEP_N, // Advance burst counter
  input wire logic CHIP_SEL_LOW_A_N, // Chip select, active low
  input wire logic CHIP_SEL_HIGH, // Chip select for depth expansion
  input wire logic BURST_ORDER_SEL, // Static burst order level
  input wire logic OUTPUT_ENABLE_N, // Asynchronous output enable
  input wire logic [pbss_pkg::PBSS_DATA_W-1:0] DATA_LANES_IN, // Data lanes, pin level
  output logic [pbss_pkg::PBSS_DATA_W-1:0] DATA_LANES_OUT, // Read data from output register
  output logic [pbss_pkg::PBSS_LANES-1:0] DATA_LANES_OE_N // Per-lane drive, low drives
);
  import pbss_pkg::*;

  pbss_state_t s;
  pbss_state_t next_s;
  logic [PBSS_DATA_W-1:0] mem [0:PBSS_WORDS-1];
  logic [PBSS_DATA_W-1:0] array_rd;
  logic [1:0] step_cnt;
  logic [1:0] step_pair;
  logic [PBSS_LANES-1:0] wr_lanes;
  logic is_write;
  logic proc_go;
  logic ctrl_go;
  logic selected;

  // Lane bit position, used by the write path; the checks use the lane constants directly
  function automatic int lane_lsb(input int lane);
    unique case (lane)
      0: lane_lsb = PBSS_LANE_A_LSB;
      1: lane_lsb = PBSS_LANE_B_LSB;
      2: lane_lsb = PBSS_LANE_C_LSB;
      default: lane_lsb = PBSS_LANE_D_LSB;
    endcase
  endfunction

  // Write decode: global wins, write enable with all four bytes behaves the same as global
  always_comb begin
    if (!GLOBAL_WRITE_N) begin
      wr_lanes = PBSS_ALL_LANES;
    end else if (!WRITE_ENABLE_N) begin
      wr_lanes = ~BYTE_WRITE_N;
    end else begin
      wr_lanes = PBSS_NO_LANES;
    end
    is_write = |wr_lanes;
  end

  // Strobe decode; processor strobe is blocked, not deselecting, when chip select is high
  assign proc_go = !PROC_ADDR_STROBE_N && !CHIP_SEL_LOW_A_N;
  assign ctrl_go = !CTRL_ADDR_STROBE_N && !proc_go;
  assign selected = !CHIP_SEL_LOW_A_N && CHIP_SEL_HIGH;

  // Counter value for this edge: stepping happens only on the step input
  assign step_cnt = BURST_STEP_N ? s.cnt : 2'(s.cnt + PBSS_CNT_STEP);

  pbss_burst_addr u_burst_addr (
    .base(s.base),
    .cnt(step_cnt),
    .order_sel(BURST_ORDER_SEL),
    .pair(step_pair)
  );

  // Array read is taken from the captured cycle address
  assign array_rd = mem[s.cyc_addr];

  // Next-state logic for the whole access pipeline
  always_comb begin
    next_s = s;
    next_s.cyc_valid = 1'b0;
    next_s.cyc_write = 1'b0;
    next_s.cyc_lanes = PBSS_NO_LANES;
    next_s.cyc_data = DATA_LANES_IN;
    // Output stage loads one edge after the array is addressed
    next_s.out_valid = s.cyc_valid && !s.cyc_write;
    if (s.cyc_valid && !s.cyc_write) begin
      next_s.out_data = array_rd;
    end
    if (proc_go || ctrl_go) begin
      if (selected) begin
        // New burst from the external address
        next_s.phase = PBSS_PH_BURST;
        next_s.base = BURST_LSB_PAIR;
        next_s.cnt = PBSS_CNT_START;
        next_s.upper = ADDRESS_IN;
        next_s.cyc_valid = 1'b1;
        next_s.cyc_addr = {ADDRESS_IN, BURST_LSB_PAIR};
        // A processor-started cycle is always a read
        next_s.cyc_write = ctrl_go && is_write;
        next_s.cyc_lanes = ctrl_go ? wr_lanes : PBSS_NO_LANES;
      end else begin
        next_s.phase = PBSS_PH_IDLE;
      end
    end else if (s.phase == PBSS_PH_BURST) begin
      // Continue or suspend with an internal address
      next_s.cnt = step_cnt;
      next_s.cyc_valid = 1'b1;
      next_s.cyc_addr = {s.upper, step_pair};
      next_s.cyc_write = is_write;
      next_s.cyc_lanes = wr_lanes;
    end
  end

  // Single state register; reset makes the pipeline idle with drivers off
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      s <= PBSS_STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  // Self-timed array write one edge after capture; no external pulse needed
  always_ff @(posedge CORE_CLK) begin
    if (!SYS_RST && s.cyc_valid && s.cyc_write) begin
      for (int l = 0; l < PBSS_LANES; l++) begin
        if (s.cyc_lanes[l]) begin
          mem[s.cyc_addr][lane_lsb(l) +: PBSS_LANE_W] <= s.cyc_data[lane_lsb(l) +: PBSS_LANE_W];
        end
      end
    end
  end

  // Data out is registered; enable is combinational from the async pin
  assign DATA_LANES_OUT = s.out_data;
  assign DATA_LANES_OE_N = {PBSS_LANES{OUTPUT_ENABLE_N || !s.out_valid}};

  // Checks on the captured pipeline
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);

  AST_CAPTURE_ADDR: assert property (
    (proc_go || ctrl_go) && selected |=> s.cyc_valid && s.cyc_addr == {$past(ADDRESS_IN), $past(BURST_LSB_PAIR)}
  ) else $error("start address not captured");

  AST_CAPTURE_DATA: assert property (
    s.cyc_valid && s.cyc_write |=> mem[$past(s.cyc_addr)][PBSS_LANE_A_LSB +: PBSS_LANE_W] ==
      ($past(s.cyc_lanes[0]) ? $past(s.cyc_data[PBSS_LANE_A_LSB +: PBSS_LANE_W])
                             : $past(mem[s.cyc_addr][PBSS_LANE_A_LSB +: PBSS_LANE_W]))
  ) else $error("lane a write result wrong");

  AST_BYTE_LANES: assert property (
    ctrl_go && selected && GLOBAL_WRITE_N && !WRITE_ENABLE_N |=> s.cyc_lanes == ~$past(BYTE_WRITE_N)
  ) else $error("byte lanes do not follow byte enables");

  AST_GLOBAL_WRITE: assert property (
    s.phase == PBSS_PH_BURST && !proc_go && !ctrl_go && !GLOBAL_WRITE_N |=> s.cyc_write && s.cyc_lanes == PBSS_ALL_LANES
  ) else $error("global write missed lanes");

  AST_ALL_BYTES: assert property (
    s.phase == PBSS_PH_BURST && !proc_go && !ctrl_go && !WRITE_ENABLE_N && BYTE_WRITE_N == PBSS_NO_LANES
    |=> s.cyc_lanes == PBSS_ALL_LANES
  ) else $error("all bytes not treated as global");

  AST_READ_PIPE: assert property (
    s.cyc_valid && !s.cyc_write |=> s.out_valid && DATA_LANES_OUT == $past(array_rd)
  ) else $error("read data not registered one edge later");

  AST_HOLD: assert property (
    s.phase == PBSS_PH_BURST && !proc_go && !ctrl_go && BURST_STEP_N |=> s.cnt == $past(s.cnt)
  ) else $error("counter moved without step");

  AST_LINEAR: assert property (
    s.phase == PBSS_PH_BURST && !proc_go && !ctrl_go && !BURST_STEP_N && BURST_ORDER_SEL == PBSS_ORDER_LINEAR
    |=> s.cyc_addr[1:0] == 2'($past(s.base) + $past(s.cnt) + PBSS_CNT_STEP)
  ) else $error("linear burst address wrong");

  AST_INTERLEAVE: assert property (
    s.phase == PBSS_PH_BURST && !proc_go && !ctrl_go && !BURST_STEP_N && BURST_ORDER_SEL == PBSS_ORDER_INTERLEAVED
    |=> s.cyc_addr[1:0] == ($past(s.base) ^ 2'($past(s.cnt) + PBSS_CNT_STEP))
  ) else $error("interleaved burst address wrong");

  AST_PROC_BLOCKED: assert property (
    s.phase == PBSS_PH_IDLE && !PROC_ADDR_STROBE_N && CHIP_SEL_LOW_A_N && CTRL_ADDR_STROBE_N
    |=> !s.cyc_valid && s.phase == PBSS_PH_IDLE
  ) else $error("blocked processor strobe started an access");

  AST_DESELECT: assert property (
    !CTRL_ADDR_STROBE_N && CHIP_SEL_LOW_A_N |=> s.phase == PBSS_PH_IDLE ##1 !s.out_valid
  ) else $error("controller strobe with select high did not deselect");

  AST_OE_ASYNC: assert property (
    OUTPUT_ENABLE_N |-> DATA_LANES_OE_N == PBSS_ALL_LANES
  ) else $error("drivers on while output enable high");

  // Further checks on capture, decode and output timing
  AST_CAPTURE_UPPER: assert property (
    (proc_go || ctrl_go) && selected |=> s.upper == $past(ADDRESS_IN)
  ) else $error("upper address not captured");

  AST_CAPTURE_WDATA: assert property (
    s.phase == PBSS_PH_BURST |=> s.cyc_data == $past(DATA_LANES_IN)
  ) else $error("write data not captured at the edge");

  AST_BASE_LOAD: assert property (
    (proc_go || ctrl_go) && selected |=> s.base == $past(BURST_LSB_PAIR) && s.cnt == PBSS_CNT_START
  ) else $error("burst counter not loaded from start pair");

  AST_START_PHASE: assert property (
    (proc_go || ctrl_go) && selected |=> s.phase == PBSS_PH_BURST
  ) else $error("strobe did not begin a burst");

  AST_CTRL_WRITE: assert property (
    ctrl_go && selected && is_write |=> s.cyc_valid && s.cyc_write
  ) else $error("controller strobe write not started");

  AST_CTRL_READ: assert property (
    ctrl_go && selected && !is_write |=> s.cyc_valid && !s.cyc_write
  ) else $error("controller strobe read not started");

  AST_PROC_READ: assert property (
    proc_go && selected |=> s.cyc_valid && !s.cyc_write
  ) else $error("processor strobe did not start a read");

  AST_PROC_WINS: assert property (
    proc_go && !CTRL_ADDR_STROBE_N && selected |=> !s.cyc_write
  ) else $error("controller strobe beat processor strobe");

  AST_SEL_HIGH_GATE: assert property (
    (proc_go || ctrl_go) && !CHIP_SEL_HIGH |=> s.phase == PBSS_PH_IDLE && !s.cyc_valid
  ) else $error("access started with expansion select low");

  AST_SEL_LOW_GATE: assert property (
    (proc_go || ctrl_go) && CHIP_SEL_LOW_A_N |=> !s.cyc_valid
  ) else $error("access started with chip select high");

  AST_STEP_ADVANCE: assert property (
    s.phase == PBSS_PH_BURST && !proc_go && !ctrl_go && !BURST_STEP_N
    |=> s.cnt == 2'($past(s.cnt) + PBSS_CNT_STEP)
  ) else $error("counter did not advance on step");

  AST_SUSPEND_UPPER: assert property (
    s.phase == PBSS_PH_BURST && !proc_go && !ctrl_go
    |=> s.cyc_valid && s.cyc_addr[PBSS_ADDR_W-1:2] == $past(s.upper)
  ) else $error("burst left its upper address");

  AST_LINEAR_HOLD: assert property (
    s.phase == PBSS_PH_BURST && !proc_go && !ctrl_go && BURST_STEP_N && BURST_ORDER_SEL == PBSS_ORDER_LINEAR
    |=> s.cyc_addr[1:0] == 2'($past(s.base) + $past(s.cnt))
  ) else $error("suspended linear address wrong");

  AST_INTERLEAVE_HOLD: assert property (
    s.phase == PBSS_PH_BURST && !proc_go && !ctrl_go && BURST_STEP_N && BURST_ORDER_SEL == PBSS_ORDER_INTERLEAVED
    |=> s.cyc_addr[1:0] == ($past(s.base) ^ $past(s.cnt))
  ) else $error("suspended interleaved address wrong");

  AST_WRITE_ALL: assert property (
    s.cyc_valid && s.cyc_write && s.cyc_lanes == PBSS_ALL_LANES |=> mem[$past(s.cyc_addr)] == $past(s.cyc_data)
  ) else $error("full word write not stored");

  // Lanes b to d mirror the lane a check, so a swapped lane shows up
  AST_LANE_B: assert property (
    s.cyc_valid && s.cyc_write |=> mem[$past(s.cyc_addr)][PBSS_LANE_B_LSB +: PBSS_LANE_W] ==
      ($past(s.cyc_lanes[1]) ? $past(s.cyc_data[PBSS_LANE_B_LSB +: PBSS_LANE_W])
                             : $past(mem[s.cyc_addr][PBSS_LANE_B_LSB +: PBSS_LANE_W]))
  ) else $error("lane b write result wrong");

  AST_LANE_C: assert property (
    s.cyc_valid && s.cyc_write |=> mem[$past(s.cyc_addr)][PBSS_LANE_C_LSB +: PBSS_LANE_W] ==
      ($past(s.cyc_lanes[2]) ? $past(s.cyc_data[PBSS_LANE_C_LSB +: PBSS_LANE_W])
                             : $past(mem[s.cyc_addr][PBSS_LANE_C_LSB +: PBSS_LANE_W]))
  ) else $error("lane c write result wrong");

  AST_LANE_D: assert property (
    s.cyc_valid && s.cyc_write |=> mem[$past(s.cyc_addr)][PBSS_LANE_D_LSB +: PBSS_LANE_W] ==
      ($past(s.cyc_lanes[3]) ? $past(s.cyc_data[PBSS_LANE_D_LSB +: PBSS_LANE_W])
                             : $past(mem[s.cyc_addr][PBSS_LANE_D_LSB +: PBSS_LANE_W]))
  ) else $error("lane d write result wrong");

  AST_READ_KEEPS: assert property (
    s.cyc_valid && !s.cyc_write |=> mem[$past(s.cyc_addr)] == $past(mem[s.cyc_addr])
  ) else $error("read cycle changed the array");

  AST_CONT_READ: assert property (
    s.phase == PBSS_PH_BURST && !proc_go && !ctrl_go && GLOBAL_WRITE_N && WRITE_ENABLE_N
    |=> !s.cyc_write
  ) else $error("continuation without write controls wrote");

  AST_CONT_BYTE: assert property (
    s.phase == PBSS_PH_BURST && !proc_go && !ctrl_go && GLOBAL_WRITE_N && !WRITE_ENABLE_N
    |=> s.cyc_lanes == ~$past(BYTE_WRITE_N)
  ) else $error("continuation lanes do not follow byte enables");

  AST_WRITE_NO_OUT: assert property (
    s.cyc_valid && s.cyc_write |=> !s.out_valid
  ) else $error("write cycle loaded the output register");

  AST_OUT_HOLD: assert property (
    !(s.cyc_valid && !s.cyc_write) |=> DATA_LANES_OUT == $past(DATA_LANES_OUT)
  ) else $error("output register changed without a read");

  AST_OE_DRIVE: assert property (
    !OUTPUT_ENABLE_N && s.out_valid |-> DATA_LANES_OE_N == PBSS_NO_LANES
  ) else $error("drivers off during enabled read");

  AST_IDLE_QUIET: assert property (
    s.phase == PBSS_PH_IDLE && !proc_go && !ctrl_go |=> !s.cyc_valid
  ) else $error("idle memory started a cycle");

  AST_DESEL_DRIVERS: assert property (
    ctrl_go && !selected |-> ##2 DATA_LANES_OE_N == PBSS_ALL_LANES
  ) else $error("drivers on after deselect");

  COV_PROC_READ: cover property (proc_go && selected ##1 s.cyc_valid ##1 s.out_valid);
  COV_CTRL_WRITE: cover property (ctrl_go && selected && is_write ##1 s.cyc_write);
  COV_FULL_BURST: cover property ((!BURST_STEP_N && s.phase == PBSS_PH_BURST && !proc_go && !ctrl_go) [*3]);
  COV_DESELECT: cover property (s.phase == PBSS_PH_BURST ##1 ctrl_go && !selected);
  COV_INTERLEAVE: cover property (BURST_ORDER_SEL == PBSS_ORDER_INTERLEAVED && !BURST_STEP_N && s.out_valid);
endmodule

// file: test/pbss_host_bus.sv
`timescale 1ns/10ps
module pbss_host_bus (
  input wire logic clk, // Bus clock
  input wire logic [35:0] host_data, // Controller write data
  input wire logic host_drive, // Controller drives the lanes
  input wire logic [35:0] dev_data, // Memory read data
  input wire logic [3:0] dev_oe_n, // Memory lane drive, low drives
  output logic [35:0] pin // Resolved lane level
);
  logic [35:0] last = 36'h0;
  // Floating lanes flip every cycle so a stale value never reads as good data
  always_comb begin
    for (int l = 0; l < 4; l++) begin
      pin[l*9 +: 9] = host_drive ? host_data[l*9 +: 9] :
        !dev_oe_n[l] ? dev_data[l*9 +: 9] : ~last[l*9 +: 9];
    end
  end
  // Remember the level for the next floating cycle
  always_ff @(posedge clk) begin
    last <= pin;
  end
endmodule

// file: test/test_pbss_sram.sv
`timescale 1ns/10ps
module test_pbss_sram;
  import pbss_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic [12:0] ua = '0;
  logic [1:0] pa = '0;
  logic [3:0] bw = 4'hF;
  logic we = 1, gw = 1, ps = 1, cs = 1, st = 1, sl = 0, sh = 1, burst_order_sel = 0, oe = 1, hd = 0;
  logic [35:0] hw = '0;
  logic [35:0] pin, dq;
  logic [3:0] doe;
  logic [35:0] m [int];
  int err_count = 0;
  int samples_checked = 0;
  // Free-running core clock, 50 ns period
  initial begin
    forever #25 clk = ~clk;
  end
  pbss_sram u_pbss_sram (.CORE_CLK(clk), .SYS_RST(rst), .ADDRESS_IN(ua), .BURST_LSB_PAIR(pa),
    .BYTE_WRITE_N(bw), .WRITE_ENABLE_N(we), .GLOBAL_WRITE_N(gw), .PROC_ADDR_STROBE_N(ps),
    .CTRL_ADDR_STROBE_N(cs), .BURST_STEP_N(st), .CHIP_SEL_LOW_A_N(sl), .CHIP_SEL_HIGH(sh),
    .BURST_ORDER_SEL(burst_order_sel), .OUTPUT_ENABLE_N(oe), .DATA_LANES_IN(pin), .DATA_LANES_OUT(dq),
    .DATA_LANES_OE_N(doe));
  pbss_host_bus u_pbss_host_bus (.clk(clk), .host_data(hw), .host_drive(hd), .dev_data(dq),
    .dev_oe_n(doe), .pin(pin));
  // Compare and count
  task chk(input logic [35:0] s, input logic [35:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  // Inputs move a fixed 5 ns after the edge
  task tick;
    @(posedge clk);
    #5;
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // One cycle started by the controller strobe; expected array updated alongside
  task wr(input int a, input logic [35:0] d, input logic [3:0] b, input logic w, g, l, h, p);
    {ua, pa} = a[14:0];
    hw = d;
    hd = 1;
    bw = b;
    we = w;
    gw = g;
    sl = l;
    sh = h;
    ps = p;
    cs = 0;
    if (!l && h && p && (!g || (!w && b != 4'hF))) begin
      for (int i = 0; i < 4; i++) if (!g || !b[i]) m[a][i*9 +: 9] = d[i*9 +: 9];
    end
    tick;
    hd = 0;
    {cs, ps, we, gw, bw, sl, sh} = {1'b1, 1'b1, 1'b1, 1'b1, 4'hF, 1'b0, 1'b1};
    // One idle edge so a following task never re-drives the strobe in this time step
    tick;
  endtask
  // Burst read of n words; order level only changes in the same time step as the new start strobe
  task rd(input int a, input int n, input logic o);
    logic [1:0] lo;
    burst_order_sel = o;
    {ua, pa} = a[14:0];
    ps = 0;
    oe = 0;
    tick;
    ps = 1;
    st = 0;
    for (int k = 0; k < n; k++) begin
      tick;
      lo = o ? a[1:0] ^ k[1:0] : a[1:0] + k[1:0];
      chk(dq, m[{a[14:2], lo}]);
      chk(doe, 4'h0);
    end
    st = 1;
    oe = 1;
    #1;
    chk(doe, 4'hF);
    tick;
  endtask
  task t_global;
    wr(16, 36'h123456789, 4'hF, 1, 0, 0, 1, 1);
    rd(16, 1, 0);
  endtask
  task t_bursts;
    for (int i = 0; i < 4; i++) wr(32 + i, 36'h111111111 * (i + 1), 4'h0, 0, 1, 0, 1, 1);
    rd(33, 4, 0);
    rd(34, 4, 1);
  endtask
  task t_bytes;
    wr(32, '1, 4'hD, 0, 1, 0, 1, 1);
    wr(33, '1, 4'h0, 0, 1, 0, 1, 1);
    wr(34, '1, 4'h0, 1, 1, 0, 1, 1);
    wr(35, '1, 4'h0, 0, 0, 0, 1, 0);
    rd(32, 4, 0);
  endtask
  task t_desel;
    wr(35, '1, 4'hF, 1, 0, 0, 0, 1);
    wr(35, '1, 4'hF, 1, 0, 1, 1, 1);
    oe = 0;
    ps = 0;
    sl = 1;
    tick;
    ps = 1;
    sl = 0;
    tick;
    tick;
    chk(doe, 4'hF);
    rd(35, 1, 0);
  endtask
  // Main sequence
  initial begin
    tick;
    tick;
    tick;
    rst = 0;
    chk(dq, '0);
    chk(doe, 4'hF);
    t_global;
    t_bursts;
    t_bytes;
    t_desel;
    wrap_up;
  end
  // Hang guard
  initial begin
    #2000000;
    err_count++;
    wrap_up;
  end
endmodule
